// ==== verilog/obl_pkg.sv ====
// Shared constants and types for the option bit loader
package obl_pkg;

	// Option byte locations in program memory
	localparam int          OBL_OPT_BYTES    = 4;
	localparam logic [1:0]  OBL_ADDR_FIRST   = 2'h0;
	localparam logic [1:0]  OBL_ADDR_LAST    = 2'h3;
	localparam logic [7:0]  OBL_ERASED_BYTE  = 8'hff;

	// Byte zero fields
	localparam int OBL_B0_OSC_HI   = 7;
	localparam int OBL_B0_OSC_LO   = 6;
	localparam int OBL_B0_WDT_ACT  = 5;
	localparam int OBL_B0_WDT_AUTO = 4;
	localparam int OBL_B0_BO_AON   = 3;
	localparam int OBL_B0_DBG_N    = 2;
	localparam int OBL_B0_FWP      = 1;
	localparam int OBL_B0_CRP      = 0;
	// Byte one fields
	localparam int OBL_B1_MOTOR_N  = 2;
	localparam int OBL_B1_HI_IDLE  = 1;
	localparam int OBL_B1_LO_IDLE  = 0;
	// Byte three field
	localparam int OBL_B3_LOWPWR   = 6;

	// Oscillator modes
	typedef enum logic [1:0] {
		OBL_OSC_EXT_RC   = 2'h0,
		OBL_OSC_LOW_PWR  = 2'h1,
		OBL_OSC_MED_PWR  = 2'h2,
		OBL_OSC_HIGH_PWR = 2'h3
	} obl_osc_type;

	// Low power start-up clock divider
	localparam int          OBL_LP_DIV       = 8;
	localparam logic [2:0]  OBL_LP_LAST      = 3'h7;

	// Software register port (8-bit data)
	localparam logic [3:0]  OBL_REG_OSC_CTRL = 4'h0;
	localparam logic [3:0]  OBL_REG_STATUS   = 4'h4;
	localparam int          OBL_CTRL_WDT_EN  = 0;
	localparam logic [7:0]  OBL_CTRL_RESET   = 8'h01;
	localparam int          OBL_ST_LOADED    = 0;
	localparam int          OBL_ST_WDT_RUN   = 1;
	localparam int          OBL_ST_LOWPWR    = 2;
	localparam int          OBL_ST_REFUSED   = 3;

	// Decoded option controls
	typedef struct packed {
		obl_osc_type oscillatorModeSelect;
		logic        watchdogTimeoutAction;
		logic        watchdogAutoEnable;
		logic        brownoutAlwaysOn;
		logic        debugSerialPortEnableN;
		logic        flashWritePermit;
		logic        codeReadPermit;
		logic        motorPinEnableN;
		logic        highSideIdleLevel;
		logic        lowSideIdleLevel;
		logic        lowPowerStartup;
	} obl_cfg_type;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} obl_bus_type;

endpackage

// ==== verilog/option_bit_loader.sv ====
// Reset-time option byte loader and decoder of the static option controls
//
// Notes on behaviour
// - Every reset kind, short reset and stop recovery included, reloads the option bytes.
// - Changed option bytes take effect only after the next reload.
// - Core stays in reset until all option bytes are loaded.
// - Loaded option values have no register address; only status bit 2 reflects the low power start-up option, inverted.
// - Option bytes are read from program memory addresses zero through three.
// - Byte zero bits 7:6 pick RC, low, medium or high crystal drive.
// - Byte zero bit 5: zero gives watchdog interrupt, one gives short reset.
// - Byte zero bit 4 zero starts watchdog at reset, else on instruction.
// - Byte zero bit 3 zero turns brown-out off in stop mode.
// - Debug serial port enabled when byte zero bit 2 is zero.
// - Byte zero bit 1 zero refuses user flash writes; debugger still allowed.
// - Byte zero bit 0 zero hides user code and limits debugger commands.
// - Erased bytes read all ones, giving the documented default settings.
// - Byte one bit 2 zero enables motor pin functions from reset.
// - Byte one bit 1 sets the high-side PWM idle level.
// - Byte one bit 0 sets the low-side PWM idle level.
// - Clearing the watchdog oscillator enable bit always stops the watchdog.
// - Byte three bit 6 zero starts in low power, clock divided by eight.
`timescale 1ns/100ps

module option_bit_loader
	import obl_pkg::*;
(
	input  wire logic        clk,             // System clock, 40 MHz
	input  wire logic        rst,             // System reset, synchronous, active high
	input  wire logic        shortResetReq,   // Short reset request, one-cycle pulse
	input  wire logic        stopRecoveryReq, // Stop mode recovery, one-cycle pulse
	output logic [1:0]       memAddr,         // Program memory byte address
	output logic             memRead,         // Program memory read strobe
	input  wire logic [7:0]  memData,         // Program memory read data
	input  wire logic        memValid,        // Program memory data valid
	output logic             coreResetHold,   // Holds the processor core in reset
	output obl_cfg_type      optCfg,          // Decoded static option controls
	input  wire obl_bus_type busReq,          // Register port request
	output logic [7:0]       busRdata,        // Register read data, one cycle later
	input  wire logic        stopMode,        // Device is in stop mode
	output logic             brownoutEnable,  // Brown-out detector enable
	input  wire logic        wdtInstr,        // Watchdog start instruction executed
	input  wire logic        wdtTimeout,      // Watchdog time-out, one-cycle pulse
	output logic             wdtRunning,      // Watchdog counting
	output logic             wdtIrq,          // Watchdog interrupt request pulse
	input  wire logic        userFlashReq,    // Program or erase request from user code
	input  wire logic        debugFlashReq,   // Program or erase request from debugger
	output logic             flashOpGrant,    // Flash operation accepted
	output logic             flashOpRefused,  // Flash operation refused pulse
	input  wire logic        userCodeReadReq, // Data read of user code
	output logic             userCodeReadOk,  // User code read allowed
	output logic             debugLimited,    // Debugger limited to basic commands
	output logic             lowPowerTick     // Flash access slot in divided clock
);

	////////////////////////////////////////////////////////////////////////////
	// Types and helpers

	typedef enum logic [1:0] {
		OBL_ISSUE,
		OBL_WAIT,
		OBL_RELEASE,
		OBL_RUN
	} obl_state_type;

	function automatic obl_cfg_type oblDecode(input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] b3);
		obl_cfg_type c;
		c.oscillatorModeSelect   = obl_osc_type'(b0[OBL_B0_OSC_HI:OBL_B0_OSC_LO]);
		c.watchdogTimeoutAction  = b0[OBL_B0_WDT_ACT];
		c.watchdogAutoEnable     = b0[OBL_B0_WDT_AUTO];
		c.brownoutAlwaysOn       = b0[OBL_B0_BO_AON];
		c.debugSerialPortEnableN = b0[OBL_B0_DBG_N];
		c.flashWritePermit       = b0[OBL_B0_FWP];
		c.codeReadPermit         = b0[OBL_B0_CRP];
		c.motorPinEnableN        = b1[OBL_B1_MOTOR_N];
		c.highSideIdleLevel      = b1[OBL_B1_HI_IDLE];
		c.lowSideIdleLevel       = b1[OBL_B1_LO_IDLE];
		c.lowPowerStartup        = b3[OBL_B3_LOWPWR];
		return c;
	endfunction

	obl_state_type state_reg;
	obl_state_type state_next;
	logic [1:0]    idx_reg;
	logic [7:0]    optByte_reg [OBL_OPT_BYTES];
	logic          reload;
	logic [7:0]    oscCtrl_reg;
	logic          wdtRun_reg;
	logic [2:0]    lpCount_reg;
	logic          refused_reg;
	logic          irq_reg;
	logic          grant_reg;
	logic          refusedPulse_reg;
	logic [7:0]    rdata_reg;
	logic          loaded;

	// Any reset kind, including a watchdog short reset, restarts the load
	assign reload = rst | shortResetReq | stopRecoveryReq
		| (wdtTimeout & wdtRun_reg & optCfg.watchdogTimeoutAction);

	assign loaded = (state_reg == OBL_RUN);

	////////////////////////////////////////////////////////////////////////////
	// Load sequencer

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			OBL_ISSUE:   state_next = OBL_WAIT;
			OBL_WAIT: begin
				if (memValid && idx_reg == OBL_ADDR_LAST) begin
					state_next = OBL_RELEASE;
				end else if (memValid) begin
					state_next = OBL_ISSUE;
				end
			end
			OBL_RELEASE: state_next = OBL_RUN;
			OBL_RUN:     state_next = OBL_RUN;
			default:     state_next = OBL_ISSUE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reload) begin
			state_reg <= OBL_ISSUE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (reload) begin
			idx_reg <= OBL_ADDR_FIRST;
		end else if (state_reg == OBL_WAIT && memValid && idx_reg != OBL_ADDR_LAST) begin
			idx_reg <= idx_reg + 2'h1;
		end
	end

	// Bytes only change during a load, so later flash edits wait for a reload
	always_ff @(posedge clk) begin
		if (reload) begin
			for (int i = 0; i < OBL_OPT_BYTES; i++) begin
				optByte_reg[i] <= OBL_ERASED_BYTE;
			end
		end else if (state_reg == OBL_WAIT && memValid) begin
			optByte_reg[idx_reg] <= memData;
		end
	end

	assign memAddr       = idx_reg;
	assign memRead       = (state_reg == OBL_ISSUE);
	assign coreResetHold = !loaded;
	// Stored bytes feed only this decoder; none of them has an address
	assign optCfg        = oblDecode(optByte_reg[0], optByte_reg[1], optByte_reg[3]);

	////////////////////////////////////////////////////////////////////////////
	// Watchdog control

	always_ff @(posedge clk) begin
		if (rst) begin
			oscCtrl_reg <= OBL_CTRL_RESET;
		end else if (busReq.wr && busReq.addr == OBL_REG_OSC_CTRL) begin
			oscCtrl_reg <= busReq.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (reload || !oscCtrl_reg[OBL_CTRL_WDT_EN]) begin
			wdtRun_reg <= 1'b0;
		end else if (state_reg == OBL_RELEASE && !optCfg.watchdogAutoEnable) begin
			wdtRun_reg <= 1'b1;
		end else if (loaded && wdtInstr) begin
			wdtRun_reg <= 1'b1;
		end
	end

	// Interrupt acceptance depends on software enabling interrupts globally
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= wdtTimeout & wdtRun_reg & !optCfg.watchdogTimeoutAction;
		end
	end

	assign wdtRunning = wdtRun_reg;
	assign wdtIrq     = irq_reg;

	////////////////////////////////////////////////////////////////////////////
	// Brown-out, protection and pin controls

	assign brownoutEnable = !stopMode || optCfg.brownoutAlwaysOn;

	always_ff @(posedge clk) begin
		if (rst) begin
			grant_reg        <= 1'b0;
			refusedPulse_reg <= 1'b0;
		end else begin
			grant_reg        <= loaded && (debugFlashReq
				|| (userFlashReq && optCfg.flashWritePermit));
			refusedPulse_reg <= loaded && userFlashReq && !debugFlashReq
				&& !optCfg.flashWritePermit;
		end
	end

	// Sticky refusal flag; a new refusal wins over a clearing write
	always_ff @(posedge clk) begin
		if (rst) begin
			refused_reg <= 1'b0;
		end else if (refusedPulse_reg) begin
			refused_reg <= 1'b1;
		end else if (busReq.wr && busReq.addr == OBL_REG_STATUS
			&& busReq.wdata[OBL_ST_REFUSED]) begin
			refused_reg <= 1'b0;
		end
	end

	assign flashOpGrant   = grant_reg;
	assign flashOpRefused = refusedPulse_reg;
	assign userCodeReadOk = loaded && userCodeReadReq && optCfg.codeReadPermit;
	assign debugLimited   = !optCfg.codeReadPermit;

	////////////////////////////////////////////////////////////////////////////
	// Low power start-up divider: one flash slot per eight clocks

	always_ff @(posedge clk) begin
		if (reload || optCfg.lowPowerStartup) begin
			lpCount_reg <= 3'h0;
		end else begin
			lpCount_reg <= lpCount_reg + 3'h1;
		end
	end

	assign lowPowerTick = optCfg.lowPowerStartup || (lpCount_reg == OBL_LP_LAST);

	////////////////////////////////////////////////////////////////////////////
	// Register port

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (busReq.rd) begin
			case (busReq.addr)
				OBL_REG_OSC_CTRL: rdata_reg <= oscCtrl_reg;
				OBL_REG_STATUS:   rdata_reg <= {4'h0, refused_reg, !optCfg.lowPowerStartup,
					wdtRun_reg, loaded};
				default:          rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign busRdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_reload_restart;
		@(posedge clk) disable iff (rst)
		(shortResetReq || stopRecoveryReq) |=> (memRead && coreResetHold && memAddr == 2'h0);
	endproperty
	a_reload_restart: assert property (p_reload_restart) else $error("reload did not restart");

	// Release only right after the last byte was taken
	property p_hold_until_loaded;
		@(posedge clk) disable iff (rst)
		$fell(coreResetHold) |-> ($past(state_reg == OBL_RELEASE)
			&& $past(memValid, 2) && $past(memAddr == OBL_ADDR_LAST, 2));
	endproperty
	a_hold_until_loaded: assert property (p_hold_until_loaded) else $error("core freed early");

	property p_release_after_last;
		@(posedge clk) disable iff (rst || reload)
		(state_reg == OBL_WAIT && memValid && memAddr == 2'h3) |=> coreResetHold
			##1 !coreResetHold;
	endproperty
	a_release_after_last: assert property (p_release_after_last) else $error("bad release");

	property p_cfg_stable;
		@(posedge clk) disable iff (rst)
		(loaded && !reload) |=> $stable(optCfg);
	endproperty
	a_cfg_stable: assert property (p_cfg_stable) else $error("config changed without reload");

	property p_defaults_on_load;
		@(posedge clk) disable iff (rst)
		reload |=> (optCfg.oscillatorModeSelect == OBL_OSC_HIGH_PWR
			&& optCfg.watchdogTimeoutAction && optCfg.brownoutAlwaysOn
			&& optCfg.codeReadPermit);
	endproperty
	a_defaults_on_load: assert property (p_defaults_on_load) else $error("not erased defaults");

	property p_byte0_decode;
		@(posedge clk) disable iff (rst || reload)
		(state_reg == OBL_WAIT && memValid && memAddr == 2'h0) |=>
			(optCfg.oscillatorModeSelect == $past(memData[7:6])
			&& optCfg.flashWritePermit == $past(memData[1])
			&& optCfg.codeReadPermit == $past(memData[0]));
	endproperty
	a_byte0_decode: assert property (p_byte0_decode) else $error("byte zero decode");

	property p_byte1_decode;
		@(posedge clk) disable iff (rst || reload)
		(state_reg == OBL_WAIT && memValid && memAddr == 2'h1) |=>
			(optCfg.motorPinEnableN == $past(memData[2])
			&& optCfg.highSideIdleLevel == $past(memData[1])
			&& optCfg.lowSideIdleLevel == $past(memData[0]));
	endproperty
	a_byte1_decode: assert property (p_byte1_decode) else $error("byte one decode");

	property p_wdt_stop;
		@(posedge clk) disable iff (rst)
		!oscCtrl_reg[OBL_CTRL_WDT_EN] |=> !wdtRunning;
	endproperty
	a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog kept running");

	property p_wdt_auto;
		@(posedge clk) disable iff (rst || reload)
		(state_reg == OBL_RELEASE && !optCfg.watchdogAutoEnable
			&& oscCtrl_reg[OBL_CTRL_WDT_EN]) |=> wdtRunning;
	endproperty
	a_wdt_auto: assert property (p_wdt_auto) else $error("watchdog not auto started");

	property p_wdt_irq;
		@(posedge clk) disable iff (rst)
		(wdtTimeout && wdtRunning && !optCfg.watchdogTimeoutAction) |=> wdtIrq;
	endproperty
	a_wdt_irq: assert property (p_wdt_irq) else $error("missing watchdog interrupt");

	property p_brownout;
		@(posedge clk) disable iff (rst)
		(stopMode && !optCfg.brownoutAlwaysOn) |-> !brownoutEnable;
	endproperty
	a_brownout: assert property (p_brownout) else $error("brown-out on in stop");

	property p_flash_refuse;
		@(posedge clk) disable iff (rst)
		(loaded && userFlashReq && !debugFlashReq && !optCfg.flashWritePermit)
			|=> (flashOpRefused && !flashOpGrant);
	endproperty
	a_flash_refuse: assert property (p_flash_refuse) else $error("user flash not refused");

	property p_read_protect;
		@(posedge clk) disable iff (rst)
		!optCfg.codeReadPermit |-> (!userCodeReadOk && debugLimited);
	endproperty
	a_read_protect: assert property (p_read_protect) else $error("code readable");

	property p_lowpower_tick;
		@(posedge clk) disable iff (rst || reload)
		(!optCfg.lowPowerStartup && lowPowerTick) |=> !lowPowerTick [*7];
	endproperty
	a_lowpower_tick: assert property (p_lowpower_tick) else $error("divider slot wrong");

	property p_single_read;
		@(posedge clk) disable iff (rst || reload)
		memRead |=> !memRead;
	endproperty
	a_single_read: assert property (p_single_read) else $error("read strobe held");

	property p_flash_grant;
		@(posedge clk) disable iff (rst)
		(loaded && userFlashReq && optCfg.flashWritePermit)
			|=> (flashOpGrant && !flashOpRefused);
	endproperty
	a_flash_grant: assert property (p_flash_grant) else $error("flash not granted");

	// Option bytes must never leak through an unused address
	property p_unmapped_read;
		@(posedge clk) disable iff (rst)
		(busReq.rd && busReq.addr != OBL_REG_OSC_CTRL && busReq.addr != OBL_REG_STATUS)
			|=> (busRdata == 8'h00);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

endmodule

// ==== tb/obl_prog_mem.sv ====
// Program memory read port model that serves the option bytes
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module obl_prog_mem (
	input  wire logic       clk,      // System clock
	input  wire logic       memRead,  // Read strobe from the loader
	input  wire logic [1:0] memAddr,  // Byte address
	output logic [7:0]      memData,  // Read data
	output logic            memValid  // Data valid pulse
);
	logic [7:0] bytes    [0:3];
	logic [1:0] seenAddr [0:3];
	logic [1:0] heldAddr;
	logic       pending;
	int         latency;
	int         cnt;
	int         reads;

	initial begin
		foreach (bytes[i]) bytes[i] = 8'hff;
		latency = 1;
		cnt = 0;
		reads = 0;
		pending = 1'b0;
		heldAddr = 2'h0;
		memValid = 1'b0;
		memData = 8'h00;
	end

	// A new read restarts the access, so reads seen during reset do no harm
	always @(posedge clk) begin
		memValid <= 1'b0;
		memData  <= ~memData; // Idle data churns so a stale byte is never mistaken
		if (memRead) begin
			pending  <= 1'b1;
			cnt      <= latency;
			heldAddr <= memAddr;
			seenAddr[reads[1:0]] <= memAddr;
			reads    <= reads + 1;
		end else if (pending && cnt <= 1) begin
			memValid <= 1'b1;
			memData  <= bytes[heldAddr];
			pending  <= 1'b0;
		end else if (pending) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the option bit loader
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module tb_top;
	import obl_pkg::*;

	logic        clk, rst, shortResetReq, stopRecoveryReq, memRead, memValid;
	logic        coreResetHold, stopMode, brownoutEnable, wdtInstr, wdtTimeout;
	logic        wdtRunning, wdtIrq, userFlashReq, debugFlashReq, flashOpGrant;
	logic        flashOpRefused, userCodeReadReq, userCodeReadOk, debugLimited, lowPowerTick;
	logic [1:0]  memAddr;
	logic [7:0]  memData, busRdata, d;
	obl_cfg_type optCfg;
	obl_bus_type busReq;
	int          miscompares, testsRun, k;

	option_bit_loader uut (.clk(clk), .rst(rst), .shortResetReq(shortResetReq),
		.stopRecoveryReq(stopRecoveryReq), .memAddr(memAddr), .memRead(memRead),
		.memData(memData), .memValid(memValid), .coreResetHold(coreResetHold),
		.optCfg(optCfg), .busReq(busReq), .busRdata(busRdata), .stopMode(stopMode),
		.brownoutEnable(brownoutEnable), .wdtInstr(wdtInstr), .wdtTimeout(wdtTimeout),
		.wdtRunning(wdtRunning), .wdtIrq(wdtIrq), .userFlashReq(userFlashReq),
		.debugFlashReq(debugFlashReq), .flashOpGrant(flashOpGrant),
		.flashOpRefused(flashOpRefused), .userCodeReadReq(userCodeReadReq),
		.userCodeReadOk(userCodeReadOk), .debugLimited(debugLimited),
		.lowPowerTick(lowPowerTick));

	obl_prog_mem mem (.clk(clk), .memRead(memRead), .memAddr(memAddr),
		.memData(memData), .memValid(memValid));

	always #12.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		testsRun++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task summarize;
		$display("Comparisons %0d mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	function automatic logic [15:0] expCfg(input logic [7:0] b0, input logic [7:0] b1,
			input logic [7:0] b3);
		return {4'h0, b0, b1[2:0], b3[6]};
	endfunction

	task automatic busWrite(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		busReq.wr <= 1'b0;
	endtask

	task automatic busRead(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		busReq.rd <= 1'b0;
		#1 v = busRdata;
	endtask

	// One-cycle pulse: 0 user flash, 1 debug flash, 2 time-out, 3 watchdog start
	task automatic pulseIn(input int which);
		@(posedge clk);
		case (which)
			0: userFlashReq <= 1'b1;
			1: debugFlashReq <= 1'b1;
			2: wdtTimeout <= 1'b1;
			default: wdtInstr <= 1'b1;
		endcase
		@(posedge clk);
		{userFlashReq, debugFlashReq, wdtTimeout, wdtInstr} <= 4'h0;
		#1;
	endtask

	task automatic waitLoad(input logic [15:0] exp);
		int n;
		int lastValid;
		n = 0;
		lastValid = -10;
		while (coreResetHold !== 1'b0) begin
			if (memValid === 1'b1) lastValid = n;
			if (n == 200) begin
				miscompares++;
				$display("ERROR loadRelease expected 0 seen %b", coreResetHold);
				summarize();
			end
			@(posedge clk);
			#1;
			n++;
		end
		check("releaseGap", 16'(n - lastValid), 16'h2);
		check("byteReads", 16'(mem.reads), 16'h4);
		for (int i = 0; i < 4; i++) check("byteAddr", mem.seenAddr[i], 16'(i));
		check("loadedCfg", optCfg, exp);
	endtask

	// kind 0 system reset, 1 short reset, 2 stop recovery
	task automatic reload(input int kind, input logic [7:0] b0, input logic [7:0] b1,
			input logic [7:0] b3, input int lat);
		mem.bytes[0] = b0;
		mem.bytes[1] = b1;
		mem.bytes[3] = b3;
		mem.latency = lat;
		mem.reads = 0;
		@(posedge clk);
		rst <= (kind == 0);
		shortResetReq <= (kind == 1);
		stopRecoveryReq <= (kind == 2);
		@(posedge clk);
		{rst, shortResetReq, stopRecoveryReq} <= 3'h0;
		#1;
		check("holdAtReload", coreResetHold, 16'h1);
		check("cfgWhileLoading", optCfg, 16'h0fff);
		waitLoad(expCfg(b0, b1, b3));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic scErased;
		waitLoad(16'h0fff);
		@(posedge clk);
		stopMode <= 1'b1;
		userCodeReadReq <= 1'b1;
		@(posedge clk);
		#1;
		check("brownoutInStop", brownoutEnable, 16'h1);
		check("normalTick", lowPowerTick, 16'h1);
		check("codeReadOpen", userCodeReadOk, 16'h1);
		check("debugFull", debugLimited, 16'h0);
		pulseIn(0);
		check("userFlashGrant", {flashOpRefused, flashOpGrant}, 16'h1);
		busRead(4'h0, d);
		check("ctrlReset", d, 16'h01);
		busRead(4'h4, d);
		check("statusIdleWdt", d, 16'h01);
		pulseIn(3);
		check("wdtStartInstr", wdtRunning, 16'h1);
		mem.reads = 0;
		pulseIn(2);
		for (k = 0; k < 3 && coreResetHold !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		check("wdtShortReset", coreResetHold, 16'h1);
		waitLoad(16'h0fff);
	endtask

	task automatic scOsc;
		for (int m = 0; m < 4; m++) begin
			reload(m % 3, {m[1:0], 6'h3f}, 8'hff, 8'hff, m + 1);
			check("oscMode", optCfg.oscillatorModeSelect, 16'(m));
		end
	endtask

	// Every option asserted in its programmed sense; reserved bits kept at ones
	task automatic scFields;
		reload(0, 8'h00, 8'hf8, 8'hbf, 2);
		check("wdtAutoStart", wdtRunning, 16'h1);
		check("brownoutOffInStop", brownoutEnable, 16'h0);
		@(posedge clk);
		stopMode <= 1'b0;
		userCodeReadReq <= 1'b1;
		@(posedge clk);
		#1;
		check("brownoutRun", brownoutEnable, 16'h1);
		check("codeReadBlocked", userCodeReadOk, 16'h0);
		check("debugLimited", debugLimited, 16'h1);
		pulseIn(0);
		check("userFlashRefused", {flashOpRefused, flashOpGrant}, 16'h2);
		pulseIn(1);
		check("debugFlashGrant", {flashOpRefused, flashOpGrant}, 16'h1);
		pulseIn(2);
		check("wdtIrq", {wdtIrq, coreResetHold}, 16'h2);
		busRead(4'h4, d);
		check("statusAll", d, 16'h0f);
		k = 0;
		repeat (16) begin
			if (lowPowerTick === 1'b1) k++;
			@(posedge clk);
			#1;
		end
		check("lowPowerTicks", 16'(k), 16'h2);
		busWrite(4'h0, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		check("wdtStopped", wdtRunning, 16'h0);
		pulseIn(3);
		check("wdtStayStopped", wdtRunning, 16'h0);
	endtask

	task automatic scHold;
		mem.bytes[0] = 8'h5a;
		mem.bytes[1] = 8'hfd;
		mem.bytes[3] = 8'hff;
		repeat (4) @(posedge clk);
		#1;
		check("cfgHeld", optCfg, expCfg(8'h00, 8'hf8, 8'hbf));
		for (int a = 0; a < 16; a++) begin
			busRead(4'(a), d);
			check("regMap", d, (a == 4) ? 16'h0d : 16'h00);
		end
		busWrite(4'h4, 8'h08);
		busRead(4'h4, d);
		check("refusedCleared", d, 16'h05);
		reload(1, 8'h5a, 8'hfd, 8'hff, 1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clk, rst, shortResetReq, stopRecoveryReq, stopMode, wdtInstr} = 6'h10;
		{wdtTimeout, userFlashReq, debugFlashReq, userCodeReadReq} = 4'h0;
		busReq = '0;
		miscompares = 0;
		testsRun = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		mem.reads = 0;
		scErased();
		scOsc();
		scFields();
		scHold();
		summarize();
	end
endmodule
